/* hw/strap_defines.vh */
// Strap field positions, encodings and pin-mux defaults for the boot strap block
`ifndef STRAP_DEFINES_VH
`define STRAP_DEFINES_VH
`define BOOT_SEL_W 2
`define BOOT_NAND 2'h0
`define BOOT_FLASH 2'h1
`define BOOT_MMCSD 2'h2
`define BOOT_UART 2'h3
`define CFG_W 4
`define CFG_GROUP_SEL_BIT 0
`define CFG_BA0_LO 1
`define CFG_BA0_HI 2
`define CFG_WIDTH_BIT 3
`define BA0_FN_BANK 2'h0
`define BA0_FN_A14 2'h1
`define BA0_FN_GPIO54 2'h2
`define BA0_FN_RSVD 2'h3
`define UPPER_PINS 4
`define REG_ADDR_W 4
`define REG_BOOT 4'h0
`define REG_CFG 4'h1
`define REG_MUX 4'h2
`define REG_W 32
`define MUX_W 4
`define MUX_GROUP_BIT 0
`define MUX_BA0_LO 1
`define MUX_BA0_HI 2
`define MUX_WIDTH_BIT 3
`define MUX_RESET 4'h0
`define RDATA_RESET 32'h0000_0000
`endif

/* hw/strap_capture.v */
// One-shot capture of strap levels after reset release
`timescale 1ns/1ns
module strap_capture #(
  parameter W = 4
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] pins_i,
  output reg [W-1:0] value_o,
  output reg done_o
);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      value_o <= {W{1'b0}};
      done_o <= 1'b0;
    end else if (!done_o) begin
      value_o <= pins_i;
      done_o <= 1'b1;
    end
  end
endmodule // strap_capture

/* hw/boot_strap_pin_config.v */
// Boot and async-interface strap capture with pin-function routing
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "strap_defines.vh"
// What this block does
// [RQ1] Sample two boot select straps at reset; 00 NAND, 01 flash, 10 MMC/SD, 11 UART.
// [RQ2] Sample four async config strap bits at reset to set interface defaults.
// [RQ3] Strap bit 3 sets data width default: 0 is 16-bit, 1 is 8-bit.
// [RQ4] Strap bits 2:1 pick bank-address-0 pin: bank, A14, GPIO 54, reserved.
// [RQ5] Upper address pins 10-13 go to address or GPIO 64-67; bit 0 sets default.
// [RQ6] Straps latch once at reset release and hold until next reset.
module boot_strap_pin_config (
  input wire clk_i,
  input wire rst_n_i,
  input wire [`REG_ADDR_W-1:0] addr_i,
  input wire [`REG_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`REG_W-1:0] rdata_o,
  input wire [`UPPER_PINS-1:0] upper_pin_i,
  input wire [`UPPER_PINS-1:0] emif_addr_upper_i,
  input wire [`UPPER_PINS-1:0] emif_addr_upper_oe_i,
  input wire [`UPPER_PINS-1:0] gpio_upper_out_i,
  input wire [`UPPER_PINS-1:0] gpio_upper_oe_i,
  output wire [`UPPER_PINS-1:0] upper_pin_o,
  output wire [`UPPER_PINS-1:0] upper_pin_oe_o,
  output wire [`UPPER_PINS-1:0] gpio_upper_in_o,
  input wire emif_ba0_i,
  input wire emif_a14_i,
  input wire gpio54_out_i,
  input wire gpio54_oe_i,
  output reg ba0_pin_o,
  output reg ba0_pin_oe_o,
  output wire gpio54_in_o,
  input wire ba0_pin_i,
  output wire straps_valid_o,
  output wire boot_nand_o,
  output wire boot_flash_o,
  output wire boot_mmcsd_o,
  output wire boot_uart_o,
  output wire [`BOOT_SEL_W-1:0] boot_select_strap_o,
  output wire [`CFG_W-1:0] async_config_strap_o,
  output wire bus_8bit_o,
  output wire [1:0] ba0_function_o,
  output wire upper_group_gpio_o,
  input wire [1:0] cfg_low_strap_i
);
  localparam STRAP_W = `BOOT_SEL_W + `CFG_W;
  localparam MUX_W = `MUX_W;

  wire [STRAP_W-1:0] strap_now;
  wire [STRAP_W-1:0] strap_raw;
  wire strap_done;
  wire [`BOOT_SEL_W-1:0] boot_sel;
  wire [`CFG_W-1:0] cfg;
  wire [`CFG_W-1:0] cfg_now;
  wire [MUX_W-1:0] mux_default;
  wire mux_write;
  wire width8;
  wire [1:0] ba0_fn;
  wire group_gpio;
  reg [MUX_W-1:0] mux_reg;
  reg [MUX_W-1:0] mux_next;
  reg [3:0] boot_onehot;
  reg [`REG_W-1:0] rdata_next;

  // Pins 13:12 carry boot select, 11:10 config 3:2; config 1:0 come from lower pins
  assign strap_now = {upper_pin_i, cfg_low_strap_i};
  assign cfg_now = strap_now[`CFG_W-1:0];

  strap_capture #(
    .W(STRAP_W)
  ) u_cap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pins_i(strap_now),
    .value_o(strap_raw),
    .done_o(strap_done)
  ); // [RQ6]

  assign straps_valid_o = strap_done; // [RQ6]
  assign boot_sel = strap_raw[STRAP_W-1:`CFG_W]; // [RQ1]
  assign cfg = strap_raw[`CFG_W-1:0]; // [RQ2]
  assign boot_select_strap_o = boot_sel; // [RQ1]
  assign async_config_strap_o = cfg; // [RQ2]

  // Boot source decode
  always @* begin
    boot_onehot = 4'h0;
    case (boot_sel)
      `BOOT_NAND: begin
        boot_onehot = 4'h1;
      end
      `BOOT_FLASH: begin
        boot_onehot = 4'h2;
      end
      `BOOT_MMCSD: begin
        boot_onehot = 4'h4;
      end
      `BOOT_UART: begin
        boot_onehot = 4'h8;
      end
      default: begin
        boot_onehot = 4'h0;
      end
    endcase
  end

  // No boot source claimed until the straps are in
  assign boot_nand_o = strap_done & boot_onehot[0]; // [RQ1]
  assign boot_flash_o = strap_done & boot_onehot[1]; // [RQ1]
  assign boot_mmcsd_o = strap_done & boot_onehot[2]; // [RQ1]
  assign boot_uart_o = strap_done & boot_onehot[3]; // [RQ1]

  // Field defaults straight from the pins on the capture edge
  assign mux_default[`MUX_WIDTH_BIT] = cfg_now[`CFG_WIDTH_BIT]; // [RQ3]
  assign mux_default[`MUX_BA0_HI:`MUX_BA0_LO] = cfg_now[`CFG_BA0_HI:`CFG_BA0_LO]; // [RQ4]
  assign mux_default[`MUX_GROUP_BIT] = cfg_now[`CFG_GROUP_SEL_BIT]; // [RQ5]

  assign mux_write = wr_i && (addr_i == `REG_MUX);

  // Strap load wins over a software write in the same cycle
  always @* begin
    mux_next = mux_reg;
    if (!strap_done) begin
      mux_next = mux_default; // [RQ2]
    end else if (mux_write) begin
      mux_next = wdata_i[MUX_W-1:0];
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_reg <= `MUX_RESET;
    end else begin
      mux_reg <= mux_next;
    end
  end

  assign width8 = mux_reg[`MUX_WIDTH_BIT]; // [RQ3]
  assign ba0_fn = mux_reg[`MUX_BA0_HI:`MUX_BA0_LO]; // [RQ4]
  assign group_gpio = mux_reg[`MUX_GROUP_BIT]; // [RQ5]
  assign bus_8bit_o = width8; // [RQ3]
  assign ba0_function_o = ba0_fn; // [RQ4]
  assign upper_group_gpio_o = group_gpio; // [RQ5]

  // Upper pins stay released until captured so the straps are readable
  genvar g;
  generate
    for (g = 0; g < `UPPER_PINS; g = g + 1) begin : upper_route
      assign upper_pin_o[g] = group_gpio ? gpio_upper_out_i[g] : emif_addr_upper_i[g]; // [RQ5]
      assign upper_pin_oe_o[g] = strap_done & (group_gpio ? gpio_upper_oe_i[g] : emif_addr_upper_oe_i[g]); // [RQ6]
      assign gpio_upper_in_o[g] = group_gpio & upper_pin_i[g]; // [RQ5]
    end
  endgenerate

  // Bank-address-0 pin function
  always @* begin
    ba0_pin_o = 1'b0;
    ba0_pin_oe_o = 1'b0;
    if (strap_done) begin
      case (ba0_fn)
        `BA0_FN_BANK: begin
          ba0_pin_o = emif_ba0_i; // [RQ4]
          ba0_pin_oe_o = 1'b1;
        end
        `BA0_FN_A14: begin
          ba0_pin_o = emif_a14_i; // [RQ4]
          ba0_pin_oe_o = 1'b1;
        end
        `BA0_FN_GPIO54: begin
          ba0_pin_o = gpio54_out_i; // [RQ4]
          ba0_pin_oe_o = gpio54_oe_i;
        end
        `BA0_FN_RSVD: begin
          ba0_pin_o = 1'b0;
          ba0_pin_oe_o = 1'b0;
        end
        default: begin
          ba0_pin_o = 1'b0;
          ba0_pin_oe_o = 1'b0;
        end
      endcase
    end
  end

  assign gpio54_in_o = (ba0_fn == `BA0_FN_GPIO54) & ba0_pin_i; // [RQ4]

  // Read data stands only in the cycle after the read strobe
  always @* begin
    rdata_next = `RDATA_RESET;
    if (rd_i) begin
      case (addr_i)
        `REG_BOOT: begin
          rdata_next[`BOOT_SEL_W-1:0] = boot_sel;
        end
        `REG_CFG: begin
          rdata_next[`CFG_W-1:0] = cfg;
        end
        `REG_MUX: begin
          rdata_next[MUX_W-1:0] = mux_reg;
        end
        default: begin
          rdata_next = `RDATA_RESET;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `RDATA_RESET;
    end else begin
      rdata_o <= rdata_next;
    end
  end
endmodule // boot_strap_pin_config

/* testbench/strap_board.sv */
// Board strap resistors on the shared upper address pins
`timescale 1ns/1ns
module strap_board(input wire [3:0] strap, oe, drv, output wire [3:0] pin);
  // Released pin falls to its resistor level
  assign pin = (oe & drv) | (~oe & strap);
endmodule // strap_board

/* testbench/strap_chk.sv */
// Assertions on strap capture and decoded defaults
`timescale 1ns/1ns
module strap_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire straps_valid_o,
  input wire bus_8bit_o,
  input wire upper_group_gpio_o,
  input wire boot_nand_o,
  input wire wr_i,
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [1:0] boot_select_strap_o,
  input wire [1:0] ba0_function_o,
  input wire [1:0] cfg_low_strap_i,
  input wire [3:0] async_config_strap_o,
  input wire [3:0] upper_pin_i,
  input wire [3:0] upper_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  boot_nand_a: assert property (straps_valid_o |-> boot_nand_o == (boot_select_strap_o == 0)) else $error("bad");
  cfg_capture_a: assert property ($rose(straps_valid_o) |-> {boot_select_strap_o, async_config_strap_o}
    == $past({upper_pin_i, cfg_low_strap_i})) else $error("bad");
  bus_width_a: assert property ($rose(straps_valid_o) |-> bus_8bit_o == async_config_strap_o[3])
    else $error("bad");
  ba0_fn_a: assert property ($rose(straps_valid_o) |-> ba0_function_o == async_config_strap_o[2:1])
    else $error("bad");
  group_sel_a: assert property ($rose(straps_valid_o) |-> upper_group_gpio_o == async_config_strap_o[0])
    else $error("bad");
  mux_write_a: assert property (straps_valid_o && wr_i && addr_i == 4'h2 |=>
    {bus_8bit_o, ba0_function_o, upper_group_gpio_o} == $past(wdata_i[3:0])) else $error("bad");
  mux_hold_a: assert property ($past(straps_valid_o) && !$past(wr_i && addr_i == 4'h2) |->
    $stable({bus_8bit_o, ba0_function_o, upper_group_gpio_o})) else $error("bad");
  pin_release_a: assert property (!straps_valid_o |-> upper_pin_oe_o == 4'h0) else $error("bad");
  strap_hold_a: assert property (straps_valid_o && $past(straps_valid_o) |-> $stable(async_config_strap_o)
    && $stable(boot_select_strap_o)) else $error("bad");
endmodule // strap_chk
bind boot_strap_pin_config strap_chk chk(.*);

/* testbench/testbench.sv */
// Self-checking bench for strap capture and hold
`timescale 1ns/1ns
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, emif_ba0_i = 0, emif_a14_i = 0, gpio54_out_i = 0, gpio54_oe_i = 0;
  logic ba0_pin_i = 0;
  logic [1:0] cfg_low_strap_i = 0;
  logic [3:0] addr_i = 0, strap = 0, emif_addr_upper_i = 0, emif_addr_upper_oe_i = 0, gpio_upper_out_i = 0, gpio_upper_oe_i = 0;
  logic [31:0] wdata_i = 0;
  wire [31:0] rdata_o;
  wire [3:0] upper_pin_i, upper_pin_o, upper_pin_oe_o, gpio_upper_in_o, async_config_strap_o;
  wire [1:0] boot_select_strap_o, ba0_function_o;
  wire ba0_pin_o, ba0_pin_oe_o, gpio54_in_o, straps_valid_o, boot_nand_o, boot_flash_o, boot_mmcsd_o, boot_uart_o;
  wire bus_8bit_o, upper_group_gpio_o;
  int checked = 0, mismatches = 0, cyc = 0;
  boot_strap_pin_config DUT(.*);
  strap_board B(.strap(strap), .oe(upper_pin_oe_o), .drv(upper_pin_o), .pin(upper_pin_i));
  always #10 clk_i = ~clk_i;
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset with given straps, check capture, then move the straps
  task t_capture(input logic [5:0] s);
    int n;
    @(posedge clk_i);
    strap <= s[5:2];
    cfg_low_strap_i <= s[1:0];
    rst_n_i <= 0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1;
    n = 0;
    while (straps_valid_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    #1 `CHK(boot_select_strap_o, s[5:4])
    `CHK({boot_uart_o, boot_mmcsd_o, boot_flash_o, boot_nand_o}, 4'h1 << s[5:4])
    `CHK(async_config_strap_o, s[3:0])
    `CHK(bus_8bit_o, s[3])
    `CHK(ba0_function_o, s[2:1])
    `CHK(upper_group_gpio_o, s[0])
    @(posedge clk_i);
    strap <= ~s[5:2];
    cfg_low_strap_i <= ~s[1:0];
    repeat (3) @(posedge clk_i);
    #1 `CHK({boot_select_strap_o, async_config_strap_o}, s)
    $display("test %h done", s);
  endtask
  task bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1 d = rdata_o;
  endtask
  // Software overrides the pin functions and the pins follow
  task t_route;
    logic [31:0] d;
    gpio_upper_out_i <= 4'ha;
    gpio_upper_oe_i <= 4'hf;
    emif_addr_upper_i <= 4'h5;
    emif_addr_upper_oe_i <= 4'hf;
    gpio54_out_i <= 1;
    gpio54_oe_i <= 1;
    emif_a14_i <= 1;
    emif_ba0_i <= 1;
    ba0_pin_i <= 1;
    bus_read(4'h0, d);
    `CHK(d, 32'h0000_0003)
    bus_read(4'h1, d);
    `CHK(d, 32'h0000_000f)
    bus_write(4'h2, 32'h0000_0005);
    bus_read(4'h2, d);
    `CHK(d, 32'h0000_0005)
    `CHK({upper_pin_o, upper_pin_oe_o, gpio_upper_in_o}, 12'hafa)
    `CHK({ba0_pin_o, ba0_pin_oe_o, gpio54_in_o, ba0_function_o}, 5'h1e)
    bus_write(4'h2, 32'h0000_0002);
    #1 `CHK({upper_pin_o, upper_pin_oe_o, gpio_upper_in_o}, 12'h5f0)
    `CHK({ba0_pin_o, ba0_pin_oe_o, gpio54_in_o, ba0_function_o}, 5'h19)
    bus_write(4'h2, 32'h0000_0008);
    #1 `CHK({bus_8bit_o, ba0_pin_o, ba0_pin_oe_o, ba0_function_o}, 5'h1c)
    bus_write(4'h2, 32'h0000_0006);
    #1 `CHK({ba0_pin_oe_o, gpio54_in_o, ba0_function_o}, 4'h3)
    gpio_upper_oe_i <= 4'h0;
    emif_addr_upper_oe_i <= 4'h0;
    gpio54_oe_i <= 0;
    $display("test route done");
  endtask
  always @(posedge clk_i) if (++cyc > 2000) begin
    mismatches++;
    report_and_stop;
  end
  initial begin
    for (int i = 0; i < 64; i++) t_capture(i[5:0]);
    t_route;
    report_and_stop;
  end
endmodule // testbench
